// File: rtl/ts_pkg.sv
// package for the thermal supervision block
`default_nettype none
package ts_pkg;
	// register map, printed offsets are indices, byte address is four times the index
	localparam logic [7:0] REG_STATUS_IDX = 8'h51;
	localparam logic [7:0] REG_EVENT_IDX = 8'h53;
	localparam logic [7:0] REG_MASK_IDX = 8'h55;
	localparam logic [7:0] REG_BUCKA_IDX = 8'h5d;
	localparam logic [7:0] REG_BUCKB_IDX = 8'h5e;
	localparam int ADDR_W = 10;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = {REG_STATUS_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_EVENT = {REG_EVENT_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_MASK = {REG_MASK_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_BUCKA = {REG_BUCKA_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_BUCKB = {REG_BUCKB_IDX, 2'b00};
	// field positions
	localparam int BIT_WARN = 2;
	localparam int BIT_CRIT = 3;
	localparam int BIT_EN = 0;
	localparam int BIT_GPI = 1;
	// reset values
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] CONT_RST = 8'h00;
	localparam logic [7:0] ZERO8 = 8'h00;
	// temperature thresholds in degrees celsius
	localparam int TEMP_W = 8;
	localparam logic [TEMP_W-1:0] TEMP_WARN_C = 8'h7d;
	localparam logic [TEMP_W-1:0] THERMAL_CRITICAL_C = 8'h8c;
	localparam logic [TEMP_W-1:0] TEMP_POR_C = 8'h96;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} ts_bus_req_t;

	typedef struct packed {
		logic warn;
		logic crit;
	} ts_flags_t;

	typedef enum logic [1:0] {
		RAIL_OFF,
		RAIL_ON,
		RAIL_TRIPPED
	} ts_rail_st_t;
endpackage
`default_nettype wire

// File: rtl/ts_thermal_supervision.sv
// thermal supervision with register port, rail enables and core reset
//
// The implementer's own choice: the plain strobed port.
`default_nettype none
module ts_thermal_supervision
	import ts_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// register port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// sensor and control pins
	input wire logic [TEMP_W-1:0] temp_i,
	input wire logic control_input_pin_i,
	// outputs
	output logic irq_out_n_o,
	output logic rail_a_enable_o,
	output logic rail_b_enable_o,
	output logic core_por_o
);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [31:0] rdata;
		ts_flags_t status;
		ts_flags_t event_l;
		logic [7:0] mask;
		logic [7:0] cont_a;
		logic [7:0] cont_b;
		ts_rail_st_t rail_a;
		ts_rail_st_t rail_b;
		logic rail_a_en;
		logic rail_b_en;
		logic pin_q;
		logic irq_n;
		logic por;
	} ts_state_t;

	ts_state_t st;
	ts_state_t next_st;
	ts_bus_req_t req;
	logic above_warn;
	logic above_crit;
	logic above_por;
	logic pin_toggle;
	logic fresh_a;
	logic fresh_b;
	logic [7:0] status_byte;
	logic [7:0] event_byte;

	assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	////////////////////////////////////////////////////////////////////////
	// threshold compare

	assign above_warn = temp_i >= TEMP_WARN_C;
	assign above_crit = temp_i >= THERMAL_CRITICAL_C;
	assign above_por = temp_i > TEMP_POR_C;
	assign pin_toggle = control_input_pin_i != st.pin_q;

	////////////////////////////////////////////////////////////////////////
	// rail enable machine

	function automatic ts_rail_st_t rail_next(input ts_rail_st_t cur, input logic crit,
		input logic en_bit, input logic fresh);
		ts_rail_st_t n;
		n = cur;
		case (cur)
			RAIL_OFF:
			begin
				if (en_bit && !crit)
					n = RAIL_ON;
			end
			RAIL_ON:
			begin
				if (crit)
					n = RAIL_TRIPPED;
				else if (!en_bit)
					n = RAIL_OFF;
			end
			RAIL_TRIPPED:
			begin
				if (!crit && fresh && en_bit)
					n = RAIL_ON;
				else if (!en_bit && !crit)
					n = RAIL_OFF;
			end
			default:
				n = RAIL_OFF;
		endcase
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		next_st = st;
		fresh_a = 1'b0;
		fresh_b = 1'b0;
		next_st.pin_q = control_input_pin_i;
		next_st.status.warn = above_warn;
		next_st.status.crit = above_crit;
		status_byte = ZERO8;
		status_byte[BIT_WARN] = st.status.warn;
		status_byte[BIT_CRIT] = st.status.crit;
		event_byte = ZERO8;
		event_byte[BIT_WARN] = st.event_l.warn;
		event_byte[BIT_CRIT] = st.event_l.crit;
		// register writes
		if (req.wr)
		begin
			case (req.addr)
				ADDR_EVENT:
				begin
					if (req.wdata[BIT_WARN])
						next_st.event_l.warn = 1'b0;
					if (req.wdata[BIT_CRIT])
						next_st.event_l.crit = 1'b0;
				end
				ADDR_MASK:
					next_st.mask = req.wdata[7:0];
				ADDR_BUCKA:
				begin
					next_st.cont_a = req.wdata[7:0];
					fresh_a = req.wdata[BIT_EN];
				end
				ADDR_BUCKB:
				begin
					next_st.cont_b = req.wdata[7:0];
					fresh_b = req.wdata[BIT_EN];
				end
				default:
				begin
				end
			endcase
		end
		// pin toggle counts as fresh enable when pin control selected
		if (pin_toggle && st.cont_a[BIT_GPI])
			fresh_a = 1'b1;
		if (pin_toggle && st.cont_b[BIT_GPI])
			fresh_b = 1'b1;
		// rising edges latch events, set wins over clear
		if (above_warn && !st.status.warn)
			next_st.event_l.warn = 1'b1;
		if (above_crit && !st.status.crit)
			next_st.event_l.crit = 1'b1;
		next_st.rail_a = rail_next(st.rail_a, above_crit,
			st.cont_a[BIT_GPI] ? control_input_pin_i : next_st.cont_a[BIT_EN], fresh_a);
		next_st.rail_b = rail_next(st.rail_b, above_crit,
			st.cont_b[BIT_GPI] ? control_input_pin_i : next_st.cont_b[BIT_EN], fresh_b);
		next_st.rail_a_en = next_st.rail_a == RAIL_ON;
		next_st.rail_b_en = next_st.rail_b == RAIL_ON;
		next_st.irq_n = !((next_st.event_l.warn && !next_st.mask[BIT_WARN])
			|| (next_st.event_l.crit && !next_st.mask[BIT_CRIT]));
		next_st.por = above_por;
		// register reads, data one cycle later
		next_st.rdata = '0;
		if (req.rd)
		begin
			case (req.addr)
				ADDR_STATUS:
					next_st.rdata = {24'h000000, status_byte};
				ADDR_EVENT:
					next_st.rdata = {24'h000000, event_byte};
				ADDR_MASK:
					next_st.rdata = {24'h000000, st.mask};
				ADDR_BUCKA:
					next_st.rdata = {24'h000000, st.cont_a};
				ADDR_BUCKB:
					next_st.rdata = {24'h000000, st.cont_b};
				default:
					next_st.rdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			st <= '0;
			st.mask <= MASK_RST;
			st.cont_a <= CONT_RST;
			st.cont_b <= CONT_RST;
			st.rail_a <= RAIL_OFF;
			st.rail_b <= RAIL_OFF;
			st.irq_n <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign rdata_o = st.rdata;
	assign irq_out_n_o = st.irq_n;
	assign rail_a_enable_o = st.rail_a_en;
	assign rail_b_enable_o = st.rail_b_en;
	assign core_por_o = st.por;

	////////////////////////////////////////////////////////////////////////
	// checks

	a_crit_rail_off: assert property (@(posedge mclk_i) disable iff (rst_i)
		$past(above_crit) |-> !rail_a_enable_o && !rail_b_enable_o)
		else $error("rail on above critical");
	a_crit_hold_off: assert property (@(posedge mclk_i) disable iff (rst_i)
		above_crit && $past(above_crit) |=> st.rail_a != RAIL_ON)
		else $error("rail a enabled during critical");
	a_warn_live: assert property (@(posedge mclk_i) disable iff (rst_i)
		##1 st.status.warn == $past(above_warn))
		else $error("warn flag not live");
	a_warn_event: assert property (@(posedge mclk_i) disable iff (rst_i)
		above_warn && !st.status.warn |=> st.event_l.warn)
		else $error("warn event not latched");
	a_crit_event: assert property (@(posedge mclk_i) disable iff (rst_i)
		above_crit && !st.status.crit |=> st.event_l.crit ##1 st.event_l.crit || $past(wr_i))
		else $error("crit event not latched");
	a_irq_held: assert property (@(posedge mclk_i) disable iff (rst_i)
		st.event_l.crit && !st.mask[BIT_CRIT] |-> !irq_out_n_o)
		else $error("irq released with pending event");
	a_por_fast: assert property (@(posedge mclk_i) disable iff (rst_i)
		above_por |=> core_por_o)
		else $error("core reset not asserted");
	a_no_auto_on: assert property (@(posedge mclk_i) disable iff (rst_i)
		st.rail_a == RAIL_TRIPPED && !fresh_a |=> st.rail_a != RAIL_ON)
		else $error("rail a restarted without fresh enable");
	a_fresh_restart: assert property (@(posedge mclk_i) disable iff (rst_i)
		st.rail_a == RAIL_TRIPPED && fresh_a && !above_crit && !st.cont_a[BIT_GPI]
		&& wr_i && addr_i == ADDR_BUCKA |=> ##1 rail_a_enable_o)
		else $error("fresh enable ignored");
	a_thresh_order: assert property (@(posedge mclk_i) disable iff (rst_i)
		above_por |-> above_crit && above_warn)
		else $error("threshold order broken");

	////////////////////////////////////////////////////////////////////////
	// rail checks

	a_rail_b_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
		above_crit && $past(above_crit)
		|=> st.rail_b != RAIL_ON)
		else $error("rail b enabled during critical");

	a_no_auto_on_b: assert property (@(posedge mclk_i) disable iff (rst_i)
		st.rail_b == RAIL_TRIPPED && !fresh_b
		|=> st.rail_b != RAIL_ON)
		else $error("rail b restarted without fresh enable");

	a_fresh_restart_b: assert property (@(posedge mclk_i) disable iff (rst_i)
		st.rail_b == RAIL_TRIPPED && fresh_b && !above_crit && !st.cont_b[BIT_GPI] && wr_i && addr_i == ADDR_BUCKB
		|=> st.rail_b == RAIL_ON)
		else $error("rail b fresh enable ignored");

	a_pin_restart: assert property (@(posedge mclk_i) disable iff (rst_i)
		st.rail_a == RAIL_TRIPPED && pin_toggle && st.cont_a[BIT_GPI] && control_input_pin_i && !above_crit
		|=> st.rail_a == RAIL_ON)
		else $error("pin toggle restart ignored");

	a_trip_rail_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		st.rail_a == RAIL_ON && above_crit
		|=> st.rail_a == RAIL_TRIPPED)
		else $error("rail a not tripped");

	a_trip_rail_b: assert property (@(posedge mclk_i) disable iff (rst_i)
		st.rail_b == RAIL_ON && above_crit
		|=> st.rail_b == RAIL_TRIPPED)
		else $error("rail b not tripped");

	a_rail_a_out: assert property (@(posedge mclk_i) disable iff (rst_i)
		1'b1
		|-> rail_a_enable_o == (st.rail_a == RAIL_ON))
		else $error("rail a output disagrees with state");

	a_rail_b_out: assert property (@(posedge mclk_i) disable iff (rst_i)
		1'b1
		|-> rail_b_enable_o == (st.rail_b == RAIL_ON))
		else $error("rail b output disagrees with state");

	////////////////////////////////////////////////////////////////////////
	// flag, event and core reset checks

	a_crit_live: assert property (@(posedge mclk_i) disable iff (rst_i)
		1'b1
		|=> st.status.crit == $past(above_crit))
		else $error("crit flag not live");

	a_crit_flag_order: assert property (@(posedge mclk_i) disable iff (rst_i)
		st.status.crit
		|-> st.status.warn)
		else $error("crit flag without warn flag");

	a_warn_irq: assert property (@(posedge mclk_i) disable iff (rst_i)
		st.event_l.warn && !st.mask[BIT_WARN]
		|-> !irq_out_n_o)
		else $error("warn event without irq");

	a_irq_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
		!(st.event_l.warn && !st.mask[BIT_WARN]) && !(st.event_l.crit && !st.mask[BIT_CRIT])
		|-> irq_out_n_o)
		else $error("irq without unmasked event");

	a_warn_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
		st.event_l.warn && !(wr_i && addr_i == ADDR_EVENT && wdata_i[BIT_WARN])
		|=> st.event_l.warn)
		else $error("warn event lost");

	a_crit_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
		st.event_l.crit && !(wr_i && addr_i == ADDR_EVENT && wdata_i[BIT_CRIT])
		|=> st.event_l.crit)
		else $error("crit event lost");

	a_por_release: assert property (@(posedge mclk_i) disable iff (rst_i)
		!above_por
		|=> !core_por_o)
		else $error("core reset without high temperature");

	////////////////////////////////////////////////////////////////////////
	// register read checks

	a_status_read: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_i && addr_i == ADDR_STATUS
		|=> rdata_o[BIT_WARN] == $past(st.status.warn) && rdata_o[BIT_CRIT] == $past(st.status.crit))
		else $error("status read wrong");

	a_event_read: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_i && addr_i == ADDR_EVENT
		|=> rdata_o[BIT_WARN] == $past(st.event_l.warn) && rdata_o[BIT_CRIT] == $past(st.event_l.crit))
		else $error("event read wrong");

endmodule // ts_thermal_supervision
`default_nettype wire

// File: verification/ts_host_model.sv
// host side model counting interrupt requests
`default_nettype none
module ts_host_model
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// interrupt line from the block
	input wire logic irq_out_n_i,
	// count of interrupt assertions
	output logic [7:0] irq_falls_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic irq_prev;
	always_ff @(posedge mclk_i)
	begin
		irq_prev <= irq_out_n_i;
		if (rst_i)
			irq_falls_o <= 8'h00;
		else if (irq_prev && !irq_out_n_i)
			irq_falls_o <= irq_falls_o + 8'h01;
	end
endmodule // ts_host_model
`default_nettype wire

// File: verification/ts_thermal_supervision_tb.sv
// testbench for the thermal supervision block
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; $display("Error %s exp %h got %h", n, e, g); end end
module ts_thermal_supervision_tb import ts_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [ADDR_W-1:0] addr_i = '0;
	logic [31:0] wdata_i = '0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [TEMP_W-1:0] temp_i = 8'h19;
	logic pin_i = 1'b0;
	logic [31:0] rdata_o;
	logic irq_n;
	logic rail_a;
	logic rail_b;
	logic por;
	logic [7:0] irq_falls;
	logic [31:0] rd_v;
	int errors = 0;
	int num_checks = 0;
	initial
	begin
		forever #12.5 mclk_i = ~mclk_i;
	end
	ts_thermal_supervision ts_thermal_supervision_i (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .temp_i(temp_i),
		.control_input_pin_i(pin_i), .irq_out_n_o(irq_n), .rail_a_enable_o(rail_a),
		.rail_b_enable_o(rail_b), .core_por_o(por));
	ts_host_model ts_host_model_i (.mclk_i(mclk_i), .rst_i(rst_i), .irq_out_n_i(irq_n), .irq_falls_o(irq_falls));
	////////////////////////////////////////////////////////////////
	task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= {24'h0, d};
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask
	task automatic heat(input logic [7:0] t);
		@(posedge mclk_i);
		temp_i <= t;
		repeat (3) @(posedge mclk_i);
		#1;
	endtask
	function automatic logic [7:0] status_exp(input logic [7:0] t);
		logic [7:0] s;
		s = 8'h00;
		s[BIT_WARN] = (t >= TEMP_WARN_C);
		s[BIT_CRIT] = (t >= THERMAL_CRITICAL_C);
		return s;
	endfunction
	task automatic expect_state(input logic [7:0] st, input logic [7:0] ev, input logic ra, input logic irqn);
		logic [31:0] d;
		`CHK("rail_a", ra, rail_a)
		`CHK("irq_n", irqn, irq_n)
		bus_rd(ADDR_STATUS, d);
		`CHK("status", {24'h0, st}, d)
		bus_rd(ADDR_EVENT, d);
		`CHK("event", {24'h0, ev}, d)
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		#1000000;
		errors++;
		summarize();
	end
	initial
	begin
		void'($urandom(32'ha650));
		repeat (16) @(posedge mclk_i);
		rst_i <= 1'b0;
		bus_rd(10'h3fc, rd_v);
		`CHK("unmapped", 32'h0, rd_v)
		bus_rd(ADDR_MASK, rd_v);
		`CHK("mask", {24'h0, MASK_RST}, rd_v)
		bus_wr(ADDR_BUCKA, 8'h01);
		bus_wr(ADDR_BUCKB, 8'h01);
		for (int i = 0; i < 8; i++)
		begin
			heat(8'($urandom_range(124, 0)));
			expect_state(status_exp(temp_i), 8'h00, 1'b1, 1'b1);
		end
		heat(8'h7c);
		expect_state(8'h00, 8'h00, 1'b1, 1'b1);
		heat(8'h7d);
		expect_state(8'h04, 8'h04, 1'b1, 1'b0);
		heat(8'h64);
		expect_state(8'h00, 8'h04, 1'b1, 1'b0);
		bus_wr(ADDR_EVENT, 8'h04);
		heat(8'h64);
		expect_state(8'h00, 8'h00, 1'b1, 1'b1);
		bus_wr(ADDR_MASK, 8'h04);
		heat(8'h8c);
		expect_state(8'h0c, 8'h0c, 1'b0, 1'b0);
		`CHK("rail_b_trip", 1'b0, rail_b)
		bus_wr(ADDR_BUCKA, 8'h01);
		heat(8'h8c);
		expect_state(8'h0c, 8'h0c, 1'b0, 1'b0);
		heat(8'h1e);
		expect_state(8'h00, 8'h0c, 1'b0, 1'b0);
		bus_wr(ADDR_EVENT, 8'h0c);
		bus_wr(ADDR_MASK, 8'h0c);
		bus_wr(ADDR_BUCKA, 8'h01);
		heat(8'h1e);
		expect_state(8'h00, 8'h00, 1'b1, 1'b1);
		`CHK("rail_b_held", 1'b0, rail_b)
		bus_wr(ADDR_BUCKB, 8'h01);
		heat(8'h1e);
		`CHK("rail_b_restart", 1'b1, rail_b)
		bus_wr(ADDR_BUCKA, 8'h03);
		pin_i <= 1'b1;
		heat(8'h1e);
		`CHK("rail_pin", 1'b1, rail_a)
		heat(8'h91);
		expect_state(8'h0c, 8'h0c, 1'b0, 1'b1);
		heat(8'h1e);
		`CHK("rail_pin_hold", 1'b0, rail_a)
		@(posedge mclk_i);
		pin_i <= 1'b0;
		heat(8'h1e);
		@(posedge mclk_i);
		pin_i <= 1'b1;
		heat(8'h1e);
		`CHK("rail_toggle", 1'b1, rail_a)
		heat(8'h96);
		`CHK("por_edge", 1'b0, por)
		heat(8'h97);
		`CHK("por", 1'b1, por)
		`CHK("host_irq", 1'b1, irq_falls > 8'h00)
		summarize();
	end
endmodule // ts_thermal_supervision_tb
`default_nettype wire
